// [mcr_pkg.sv]
package mcr_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_EEPROM_POS  = 8'h12;
    localparam logic [7:0] IDX_MISC_CTRL   = 8'h13;
    localparam logic [7:0] IDX_TEST_ZERO   = 8'h14;
    localparam logic [7:0] IDX_TEST_ONE    = 8'h17;
    localparam logic [7:0] IDX_ALLOC_SIZE  = 8'h1c;
    localparam int unsigned BYTES_PER_REG  = 4;
    localparam int unsigned PADDR_W        = 8;

    // eeprom_position fields
    localparam int unsigned EE_BASE_LSB    = 3;
    localparam int unsigned EE_EN_BIT      = 0;
    localparam int unsigned EE_ADDR_LSB    = 11;
    // misc_system_control fields
    localparam int unsigned STRETCH_LSB    = 2;
    localparam int unsigned UPPER_HALF_BIT = 1;
    localparam int unsigned FLASH_EN_BIT   = 0;
    // memory_allocation_size fields
    localparam int unsigned REG_SW_BIT     = 7;
    localparam int unsigned EEP_SW_LSB     = 4;
    localparam int unsigned RAM_SW_LSB     = 0;

    // Reset values
    localparam logic [1:0] STRETCH_RESET    = 2'h3;
    localparam logic       UPPER_HALF_RESET = 1'b0;
    localparam logic [7:0] TEST_REG_VALUE   = 8'h00;

    // Memory sizes in bytes
    localparam logic [15:0] SIZE_1K  = 16'h0400;
    localparam logic [15:0] SIZE_2K  = 16'h0800;
    localparam logic [15:0] SIZE_4K  = 16'h1000;
    localparam logic [15:0] SIZE_8K  = 16'h2000;
    localparam logic [15:0] SIZE_16K = 16'h4000;

    // Operating modes; peripheral mode counts as a special mode
    typedef enum logic [2:0] {
        MODE_SPECIAL_SINGLE   = 3'h0,
        MODE_SPECIAL_TEST     = 3'h1,
        MODE_PERIPHERAL       = 3'h2,
        MODE_SPECIAL_EXPANDED = 3'h3,
        MODE_NORMAL_SINGLE    = 3'h4,
        MODE_NORMAL_EXPANDED  = 3'h5,
        MODE_EMUL_SINGLE      = 3'h6,
        MODE_EMUL_EXPANDED    = 3'h7
    } mcr_mode_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_RESP = 1'b1
    } mcr_bus_state_t;

    // APB request from the master
    typedef struct packed {
        logic               psel;
        logic               penable;
        logic               pwrite;
        logic [PADDR_W-1:0] paddr;
        logic [31:0]        pwdata;
        logic [3:0]         pstrb;
    } mcr_apb_req_t;

    // Settings handed to the address decoder and stretch logic
    typedef struct packed {
        logic        eeprom_map_enable;
        logic [4:0]  eeprom_base_upper_bits;
        logic [1:0]  external_stretch_field;
        logic [1:0]  stretch_cycles;
        logic        flash_upper_half_only;
        logic        flash_map_enable;
        logic        flash_lower_half_visible;
    } mcr_map_t;

    // Sizes and placements derived from the integration switches
    typedef struct packed {
        logic [15:0] register_space_bytes;
        logic [15:0] eeprom_alloc_bytes;
        logic [15:0] ram_alloc_bytes;
        logic [15:0] ram_region_bytes;
        logic [2:0]  ram_position_bits;
        logic [15:0] ram_reset_base;
        logic [15:0] ram_start_offset;
        logic [15:0] ram_base_mask;
    } mcr_alloc_t;

endpackage

// [mcr_regs.sv]
// What this block does
// - EEPROM enable bit writable always, every mode
// - EEPROM base writable always, or once option
// - Register writes reach mapping one cycle later
// - Position bits 7:3 give EEPROM base upper
// - Position bit 0 maps or hides EEPROM
// - Stretch field: once normal/emulation, free special
// - External accesses stretched by field value E clocks
// - Stretch ignored in single chip, peripheral modes
// - Visibility bit blocks lower-half flash pages
// - Flash enable bit maps or removes flash
// - Flash bits: once normal/emulation, free special
// - Control register reset values, flash enable by mode
// - Test registers readable, writes change nothing
// - Size register shows switches, ignores writes
// - Size bit 7 shows register space switch
// - Size bits 5:4 show EEPROM allocation
// - RAM switch bits show 2K to 16K
// - RAM code sets region, position bits, base
// - High-align places small RAM at region top
// - Register block takes 1K or 2K bytes
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`default_nettype none

module mcr_regs #(
    parameter logic [7:0] EEPROM_POS_RESET   = 8'h00,
    parameter bit         EE_BASE_WRITE_ONCE = 1'b0,
    parameter bit         FLASH_EN_EXPANDED  = 1'b0,
    parameter bit         REG_SPACE_SWITCH   = 1'b0,
    parameter logic [1:0] EEPROM_SIZE_SWITCH = 2'h0,
    parameter logic [2:0] RAM_SIZE_SWITCH    = 3'h0
) (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    // APB slave
    input  wire mcr_pkg::mcr_apb_req_t apb_req,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Operating mode from the core, same clock
    input  wire mcr_pkg::mcr_mode_t   op_mode,
    // Decoder side
    input  wire logic                 ram_high_align,
    input  wire logic [15:0]          cpu_addr,
    output logic                      eeprom_hit,
    output mcr_pkg::mcr_map_t         map_cfg,
    output mcr_pkg::mcr_alloc_t       alloc_cfg
);

    localparam logic [7:0] ADDR_EEPROM_POS =
        8'(mcr_pkg::IDX_EEPROM_POS * mcr_pkg::BYTES_PER_REG);
    localparam logic [7:0] ADDR_MISC_CTRL =
        8'(mcr_pkg::IDX_MISC_CTRL * mcr_pkg::BYTES_PER_REG);
    localparam logic [7:0] ADDR_TEST_ZERO =
        8'(mcr_pkg::IDX_TEST_ZERO * mcr_pkg::BYTES_PER_REG);
    localparam logic [7:0] ADDR_TEST_ONE =
        8'(mcr_pkg::IDX_TEST_ONE * mcr_pkg::BYTES_PER_REG);
    localparam logic [7:0] ADDR_ALLOC_SIZE =
        8'(mcr_pkg::IDX_ALLOC_SIZE * mcr_pkg::BYTES_PER_REG);

    typedef struct packed {
        mcr_pkg::mcr_bus_state_t bus;
        logic [31:0]             rdata;
        logic                    slverr;
        logic                    init_done;
        logic [4:0]              ee_base;
        logic                    ee_en;
        logic                    ee_locked;
        logic [1:0]              stretch;
        logic                    upper_half;
        logic                    flash_en;
        logic                    misc_locked;
    } mcr_state_t;

    mcr_state_t state_q;
    mcr_state_t state_d;

    logic       special_mode;
    logic       expanded_mode;
    logic       flash_reset_val;
    logic       access;
    logic       mapped;
    logic [7:0] read_byte;
    logic [7:0] size_byte;
    logic [7:0] wbyte;
    logic       wr_commit;
    logic       ee_wr_hit;
    logic       misc_wr_hit;
    logic       ee_base_wr_ok;
    logic       misc_wr_ok;
    logic [7:0] ee_read;
    logic [7:0] misc_read;
    logic [15:0] ee_mask;
    logic [15:0] ee_window_base;

    // Mode table; single chip and peripheral modes have no bus to stretch
    always_comb begin
        special_mode    = 1'b0;
        expanded_mode   = 1'b0;
        flash_reset_val = 1'b1;
        case (op_mode)
            mcr_pkg::MODE_SPECIAL_SINGLE: begin
                special_mode    = 1'b1;
                expanded_mode   = 1'b0;
                flash_reset_val = 1'b1;
            end
            mcr_pkg::MODE_SPECIAL_TEST: begin
                special_mode    = 1'b1;
                expanded_mode   = 1'b1;
                flash_reset_val = 1'b0;
            end
            mcr_pkg::MODE_PERIPHERAL: begin
                special_mode    = 1'b1;
                expanded_mode   = 1'b0;
                flash_reset_val = 1'b1;
            end
            mcr_pkg::MODE_SPECIAL_EXPANDED: begin
                special_mode    = 1'b1;
                expanded_mode   = 1'b1;
                flash_reset_val = FLASH_EN_EXPANDED;
            end
            mcr_pkg::MODE_NORMAL_SINGLE: begin
                special_mode    = 1'b0;
                expanded_mode   = 1'b0;
                flash_reset_val = 1'b1;
            end
            mcr_pkg::MODE_NORMAL_EXPANDED: begin
                special_mode    = 1'b0;
                expanded_mode   = 1'b1;
                flash_reset_val = FLASH_EN_EXPANDED;
            end
            mcr_pkg::MODE_EMUL_SINGLE: begin
                special_mode    = 1'b0;
                expanded_mode   = 1'b0;
                flash_reset_val = 1'b1;
            end
            mcr_pkg::MODE_EMUL_EXPANDED: begin
                special_mode    = 1'b0;
                expanded_mode   = 1'b1;
                flash_reset_val = FLASH_EN_EXPANDED;
            end
            default: begin
                special_mode = 1'b0;
            end
        endcase
    end

    // Switch visibility register; unused bits stay zero
    always_comb begin
        size_byte = 8'h00;
        size_byte[mcr_pkg::REG_SW_BIT] = REG_SPACE_SWITCH;
        size_byte[mcr_pkg::EEP_SW_LSB +: 2] = EEPROM_SIZE_SWITCH;
        size_byte[mcr_pkg::RAM_SW_LSB +: 3] = RAM_SIZE_SWITCH;
    end

    assign access = apb_req.psel && apb_req.penable;
    assign wbyte  = apb_req.pwdata[7:0];

    // Unimplemented bit positions are tied low, so they read as zero
    assign ee_read   = {state_q.ee_base, 2'h0, state_q.ee_en};
    assign misc_read = {4'h0, state_q.stretch, state_q.upper_half,
                        state_q.flash_en};

    // Read mux and address decode
    always_comb begin
        mapped    = 1'b1;
        read_byte = 8'h00;
        case (apb_req.paddr)
            ADDR_EEPROM_POS: begin
                read_byte = ee_read;
            end
            ADDR_MISC_CTRL: begin
                read_byte = misc_read;
            end
            ADDR_TEST_ZERO,
            ADDR_TEST_ONE: begin
                read_byte = mcr_pkg::TEST_REG_VALUE;
            end
            ADDR_ALLOC_SIZE: begin
                read_byte = size_byte;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // A write lands at the edge where pready is sampled high
    assign wr_commit = access && apb_req.pwrite && apb_req.pstrb[0]
                       && (state_q.bus == mcr_pkg::BUS_RESP) && mapped;

    // Write-once fields lock on the first write outside special modes
    assign ee_wr_hit     = wr_commit && (apb_req.paddr == ADDR_EEPROM_POS);
    assign misc_wr_hit   = wr_commit && (apb_req.paddr == ADDR_MISC_CTRL);
    assign ee_base_wr_ok = !EE_BASE_WRITE_ONCE || special_mode
                           || !state_q.ee_locked;
    assign misc_wr_ok    = special_mode || !state_q.misc_locked;

    always_comb begin
        state_d = state_q;
        // Flash enable reset value depends on the mode seen after reset
        if (!state_q.init_done) begin
            state_d.init_done = 1'b1;
            state_d.flash_en  = flash_reset_val;
        end

        // One wait state on every access so read data leaves a flip-flop
        case (state_q.bus)
            mcr_pkg::BUS_IDLE: begin
                if (access) begin
                    state_d.bus    = mcr_pkg::BUS_RESP;
                    state_d.rdata  = {24'h000000, read_byte};
                    state_d.slverr = !mapped;
                end
            end
            mcr_pkg::BUS_RESP: begin
                state_d.bus = mcr_pkg::BUS_IDLE;
            end
            default: begin
                state_d.bus = mcr_pkg::BUS_IDLE;
            end
        endcase

        if (ee_wr_hit) begin
            state_d.ee_en = wbyte[mcr_pkg::EE_EN_BIT];
            if (ee_base_wr_ok) begin
                state_d.ee_base = wbyte[mcr_pkg::EE_BASE_LSB +: 5];
            end
            if (EE_BASE_WRITE_ONCE && !special_mode) begin
                state_d.ee_locked = 1'b1;
            end
        end

        // Any write spends the one allowed write, even with unchanged data
        if (misc_wr_hit) begin
            if (misc_wr_ok) begin
                state_d.stretch =
                    wbyte[mcr_pkg::STRETCH_LSB +: 2];
                state_d.upper_half =
                    wbyte[mcr_pkg::UPPER_HALF_BIT];
                state_d.flash_en =
                    wbyte[mcr_pkg::FLASH_EN_BIT];
            end
            if (!special_mode) begin
                state_d.misc_locked = 1'b1;
            end
        end
        // Test and size registers take no write at all
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q.bus         <= mcr_pkg::BUS_IDLE;
            state_q.rdata       <= 32'h00000000;
            state_q.slverr      <= 1'b0;
            state_q.init_done   <= 1'b0;
            state_q.ee_base     <= EEPROM_POS_RESET[mcr_pkg::EE_BASE_LSB +: 5];
            state_q.ee_en       <= EEPROM_POS_RESET[mcr_pkg::EE_EN_BIT];
            state_q.ee_locked   <= 1'b0;
            state_q.stretch     <= mcr_pkg::STRETCH_RESET;
            state_q.upper_half  <= mcr_pkg::UPPER_HALF_RESET;
            state_q.flash_en    <= 1'b0;
            state_q.misc_locked <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    assign pready  = (state_q.bus == mcr_pkg::BUS_RESP);
    assign prdata  = state_q.rdata;
    assign pslverr = state_q.slverr;

    // Outputs come straight from the registers, so a write shows next cycle
    always_comb begin
        map_cfg.eeprom_map_enable      = state_q.ee_en;
        map_cfg.eeprom_base_upper_bits = state_q.ee_base;
        map_cfg.external_stretch_field = state_q.stretch;
        if (expanded_mode) begin
            map_cfg.stretch_cycles = state_q.stretch;
        end else begin
            map_cfg.stretch_cycles = 2'h0;
        end
        map_cfg.flash_upper_half_only  = state_q.upper_half;
        map_cfg.flash_map_enable       = state_q.flash_en;
        map_cfg.flash_lower_half_visible =
            state_q.flash_en && !state_q.upper_half;
    end

    // Allocation tables from the integration switches
    always_comb begin
        if (REG_SPACE_SWITCH) begin
            alloc_cfg.register_space_bytes = mcr_pkg::SIZE_2K;
        end else begin
            alloc_cfg.register_space_bytes = mcr_pkg::SIZE_1K;
        end

        case (EEPROM_SIZE_SWITCH)
            2'h1:    alloc_cfg.eeprom_alloc_bytes = mcr_pkg::SIZE_2K;
            2'h2:    alloc_cfg.eeprom_alloc_bytes = mcr_pkg::SIZE_4K;
            2'h3:    alloc_cfg.eeprom_alloc_bytes = mcr_pkg::SIZE_8K;
            default: alloc_cfg.eeprom_alloc_bytes = 16'h0000;
        endcase
        alloc_cfg.ram_alloc_bytes = 16'(({13'h0000, RAM_SIZE_SWITCH} + 16'h1)
                                        * mcr_pkg::SIZE_2K);
        case (RAM_SIZE_SWITCH)
            3'h0: begin
                alloc_cfg.ram_region_bytes  = mcr_pkg::SIZE_2K;
                alloc_cfg.ram_position_bits = 3'h5;
                alloc_cfg.ram_reset_base    = 16'h0800;
            end
            3'h1: begin
                alloc_cfg.ram_region_bytes  = mcr_pkg::SIZE_4K;
                alloc_cfg.ram_position_bits = 3'h4;
                alloc_cfg.ram_reset_base    = 16'h0000;
            end
            3'h2: begin
                alloc_cfg.ram_region_bytes  = mcr_pkg::SIZE_8K;
                alloc_cfg.ram_position_bits = 3'h3;
                alloc_cfg.ram_reset_base    = 16'h0800;
            end
            3'h3: begin
                alloc_cfg.ram_region_bytes  = mcr_pkg::SIZE_8K;
                alloc_cfg.ram_position_bits = 3'h3;
                alloc_cfg.ram_reset_base    = 16'h0000;
            end
            3'h4: begin
                alloc_cfg.ram_region_bytes  = mcr_pkg::SIZE_16K;
                alloc_cfg.ram_position_bits = 3'h2;
                alloc_cfg.ram_reset_base    = 16'h1800;
            end
            3'h5: begin
                alloc_cfg.ram_region_bytes  = mcr_pkg::SIZE_16K;
                alloc_cfg.ram_position_bits = 3'h2;
                alloc_cfg.ram_reset_base    = 16'h1000;
            end
            3'h6: begin
                alloc_cfg.ram_region_bytes  = mcr_pkg::SIZE_16K;
                alloc_cfg.ram_position_bits = 3'h2;
                alloc_cfg.ram_reset_base    = 16'h0800;
            end
            3'h7: begin
                alloc_cfg.ram_region_bytes  = mcr_pkg::SIZE_16K;
                alloc_cfg.ram_position_bits = 3'h2;
                alloc_cfg.ram_reset_base    = 16'h0000;
            end
            default: begin
                alloc_cfg.ram_region_bytes  = mcr_pkg::SIZE_16K;
                alloc_cfg.ram_position_bits = 3'h2;
                alloc_cfg.ram_reset_base    = 16'h0000;
            end
        endcase

        alloc_cfg.ram_base_mask = ~(alloc_cfg.ram_region_bytes - 16'h1);
        // Unused part of the region sits above or below the RAM
        if (ram_high_align) begin
            alloc_cfg.ram_start_offset =
                alloc_cfg.ram_region_bytes - alloc_cfg.ram_alloc_bytes;
        end else begin
            alloc_cfg.ram_start_offset = 16'h0000;
        end
    end

    // EEPROM window compare; size comes from the allocation switch.
    // A base not aligned to the window size is rounded down to it.
    assign ee_window_base =
        16'(state_q.ee_base) << mcr_pkg::EE_ADDR_LSB;
    assign ee_mask    = ~(alloc_cfg.eeprom_alloc_bytes - 16'h1);
    assign eeprom_hit = state_q.ee_en
        && (alloc_cfg.eeprom_alloc_bytes != 16'h0000)
        && ((cpu_addr & ee_mask)
            == (ee_window_base & ee_mask));

endmodule

`default_nettype wire

// [mcr_regs_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module mcr_regs_monitor (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  arst_n,
    // Register bus
    input wire mcr_pkg::mcr_apb_req_t apb_req,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Mode and decoder side
    input wire mcr_pkg::mcr_mode_t    op_mode,
    input wire logic                  ram_high_align,
    input wire logic [15:0]           cpu_addr,
    input wire logic                  eeprom_hit,
    input wire mcr_pkg::mcr_map_t     map_cfg,
    input wire mcr_pkg::mcr_alloc_t   alloc_cfg
);
    logic        acc;
    logic        ee_wr;
    logic        misc_wr;
    logic        mapped;
    logic        hit_exp;
    logic [15:0] ee_base;
    logic [16:0] ee_end;
    assign acc = apb_req.psel & apb_req.penable & pready
        & apb_req.pwrite & apb_req.pstrb[0];
    assign ee_wr = acc && apb_req.paddr == 8'h48;
    assign misc_wr = acc && apb_req.paddr == 8'h4c;
    assign mapped = apb_req.paddr inside {8'h48, 8'h4c, 8'h50, 8'h5c, 8'h70};
    assign ee_base = {map_cfg.eeprom_base_upper_bits, 11'h000};
    assign ee_end = {1'b0, ee_base} + {1'b0, alloc_cfg.eeprom_alloc_bytes};
    // Window must also vanish when no EEPROM is allocated
    assign hit_exp = map_cfg.eeprom_map_enable
        && alloc_cfg.eeprom_alloc_bytes != 16'h0000
        && cpu_addr >= ee_base && {1'b0, cpu_addr} < ee_end;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_first_access;
        apb_req.psel && apb_req.penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    AST_PREADY_WAIT: assert property (s_first_access |=> s_answer)
        else $error("pready not one cycle after first access cycle");
    AST_SLVERR_MAP: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    AST_EE_ENABLE: assert property (ee_wr |=>
        map_cfg.eeprom_map_enable == $past(apb_req.pwdata[0]))
        else $error("eeprom enable write lost");
    AST_EE_BASE: assert property (ee_wr |=>
        map_cfg.eeprom_base_upper_bits == $past(apb_req.pwdata[7:3]))
        else $error("eeprom base write lost");
    AST_EE_HOLD: assert property (!ee_wr |=>
        $stable(map_cfg.eeprom_base_upper_bits)
        && $stable(map_cfg.eeprom_map_enable))
        else $error("eeprom position changed without a write");
    AST_MISC_SPECIAL: assert property (misc_wr && !op_mode[2] |=>
        map_cfg.external_stretch_field == $past(apb_req.pwdata[3:2])
        && map_cfg.flash_upper_half_only == $past(apb_req.pwdata[1])
        && map_cfg.flash_map_enable == $past(apb_req.pwdata[0]))
        else $error("control write in special mode lost");
    AST_STRETCH_ON: assert property (op_mode[0] |->
        map_cfg.stretch_cycles == map_cfg.external_stretch_field)
        else $error("stretch count differs from field");
    AST_STRETCH_OFF: assert property (!op_mode[0] |->
        map_cfg.stretch_cycles == 2'h0)
        else $error("stretch active in single chip mode");
    AST_FLASH_VIS: assert property (map_cfg.flash_lower_half_visible ==
        (map_cfg.flash_map_enable & ~map_cfg.flash_upper_half_only))
        else $error("lower half flash visibility wrong");
    AST_EE_HIT: assert property (eeprom_hit == hit_exp)
        else $error("eeprom hit wrong");
endmodule

bind mcr_regs mcr_regs_monitor i_mon (
    .sys_clk(sys_clk), .arst_n(arst_n), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_mode(op_mode), .ram_high_align(ram_high_align),
    .cpu_addr(cpu_addr), .eeprom_hit(eeprom_hit),
    .map_cfg(map_cfg), .alloc_cfg(alloc_cfg)
);
`default_nettype wire

// [mcr_cpu_model.sv]
`timescale 1ns/1ns
`default_nettype none
module mcr_cpu_model (
    // Clock
    input wire logic                  sys_clk,
    // Register bus master
    output var mcr_pkg::mcr_apb_req_t apb_req,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr
);
    initial apb_req = '0;

    // Waits for pready without assuming the wait count; the bench
    // watchdog ends a hang
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [7:0] d, output logic [31:0] q,
                        output logic e);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                     pwdata: {24'h0, d}, pstrb: 4'h1};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// [mcr_regs_test.sv]
`timescale 1ns/1ns
`default_nettype none
module mcr_regs_test;
    localparam logic [7:0] A_EE = 8'h48;
    localparam logic [7:0] A_MISC = 8'h4c;
    localparam logic [7:0] A_SIZE = 8'h70;
    logic                  sys_clk;
    logic                  arst_n;
    logic                  ram_high_align;
    logic                  pready;
    logic                  pslverr;
    logic                  eeprom_hit;
    logic                  e;
    logic [15:0]           cpu_addr;
    logic [31:0]           prdata;
    logic [31:0]           q;
    mcr_pkg::mcr_apb_req_t apb_req;
    mcr_pkg::mcr_mode_t    op_mode;
    mcr_pkg::mcr_map_t     map_cfg;
    mcr_pkg::mcr_alloc_t   alloc_cfg;
    int                    n_errors;
    int                    comparisons;

    initial begin
        sys_clk = 1'b0;
        arst_n = 1'b0;
        op_mode = mcr_pkg::MODE_SPECIAL_SINGLE;
        ram_high_align = 1'b0;
        cpu_addr = 16'h0000;
        n_errors = 0;
        comparisons = 0;
    end
    always #25 sys_clk = ~sys_clk;

    mcr_regs #(.EEPROM_POS_RESET(8'h08), .FLASH_EN_EXPANDED(1'b1),
        .REG_SPACE_SWITCH(1'b1),
        .EEPROM_SIZE_SWITCH(2'h2), .RAM_SIZE_SWITCH(3'h4)) i_dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .op_mode(op_mode), .ram_high_align(ram_high_align),
        .cpu_addr(cpu_addr), .eeprom_hit(eeprom_hit),
        .map_cfg(map_cfg), .alloc_cfg(alloc_cfg));
    mcr_cpu_model i_cpu (.sys_clk(sys_clk), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_cpu.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        i_cpu.xfer(1'b0, a, 8'h00, q, e);
        chk(q, exp);
        chk(32'(e), 32'h0);
    endtask
    task automatic probe(input logic [15:0] a, input logic h);
        cpu_addr <= a;
        @(negedge sys_clk);
        chk(32'(eeprom_hit), 32'(h));
        @(posedge sys_clk);
    endtask
    // Mode is held steady across the release, as the flash reset needs
    task automatic do_reset(input mcr_pkg::mcr_mode_t m);
        arst_n <= 1'b0;
        op_mode <= m;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic end_sim;
        if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        do_reset(mcr_pkg::MODE_SPECIAL_SINGLE);
        rd(A_MISC, 32'h0d);
        rd(A_EE, 32'h08);
        rd(A_SIZE, 32'ha4);
        chk(32'(map_cfg.stretch_cycles), 32'h0);
        wr(8'h50, 8'hff);
        rd(8'h50, 32'h0);
        wr(8'h5c, 8'hff);
        rd(8'h5c, 32'h0);
        wr(A_SIZE, 8'hff);
        rd(A_SIZE, 32'ha4);
        i_cpu.xfer(1'b0, 8'h00, 8'h00, q, e);
        chk(32'(e), 32'h1);
        wr(A_MISC, 8'hf6);
        rd(A_MISC, 32'h06);
        chk(32'(map_cfg.flash_lower_half_visible), 32'h0);
        wr(A_MISC, 8'h0b);
        rd(A_MISC, 32'h0b);
        chk(32'(map_cfg.flash_lower_half_visible), 32'h0);
        wr(A_MISC, 8'h09);
        chk(32'(map_cfg.flash_lower_half_visible), 32'h1);
        wr(A_MISC, 8'h08);
        chk(32'(map_cfg.flash_map_enable), 32'h0);
        wr(A_EE, 8'h41);
        probe(16'h3fff, 1'b0);
        probe(16'h4000, 1'b1);
        probe(16'h4fff, 1'b1);
        probe(16'h5000, 1'b0);
        wr(A_EE, 8'h40);
        probe(16'h4000, 1'b0);
        chk(32'(alloc_cfg.ram_reset_base), 32'h1800);
        chk(32'(alloc_cfg.ram_region_bytes), 32'h4000);
        chk(32'(alloc_cfg.ram_position_bits), 32'h2);
        chk(32'(alloc_cfg.ram_base_mask), 32'hc000);
        chk(32'(alloc_cfg.ram_alloc_bytes), 32'h2800);
        chk(32'(alloc_cfg.eeprom_alloc_bytes), 32'h1000);
        chk(32'(alloc_cfg.register_space_bytes), 32'h800);
        chk(32'(alloc_cfg.ram_start_offset), 32'h0);
        ram_high_align <= 1'b1;
        @(posedge sys_clk);
        chk(32'(alloc_cfg.ram_start_offset), 32'h1800);
        do_reset(mcr_pkg::MODE_SPECIAL_EXPANDED);
        for (int k = 0; k < 4; k++) begin
            wr(A_MISC, 8'(k * 4 + 1));
            chk(32'(map_cfg.stretch_cycles), 32'(k));
        end
        do_reset(mcr_pkg::MODE_SPECIAL_TEST);
        rd(A_MISC, 32'h0c);
        do_reset(mcr_pkg::MODE_PERIPHERAL);
        rd(A_MISC, 32'h0d);
        chk(32'(map_cfg.stretch_cycles), 32'h0);
        do_reset(mcr_pkg::MODE_NORMAL_EXPANDED);
        rd(A_MISC, 32'h0d);
        chk(32'(map_cfg.stretch_cycles), 32'h3);
        wr(A_MISC, 8'h06);
        wr(A_MISC, 8'h09);
        rd(A_MISC, 32'h06);
        chk(32'(map_cfg.stretch_cycles), 32'h1);
        wr(A_EE, 8'h81);
        wr(A_EE, 8'h30);
        rd(A_EE, 32'h30);
        end_sim;
    end

    // About eighteen times the cycles the sequence needs
    initial begin
        repeat (3000) @(posedge sys_clk);
        n_errors++;
        end_sim;
    end
endmodule
`default_nettype wire
